// [rtl/psp_regs.vh]
// Register map, field positions and reset values of the power stage
// protection block. Definitions only; included by the design files.
`ifndef PSP_REGS_VH
`define PSP_REGS_VH

// Register indices; byte address is four times the index
`define PSP_IDX_BRIDGE_CFG 8'h02
`define PSP_IDX_SYS_CTRL 8'h03
`define PSP_IDX_POUT 8'h0B
`define PSP_IDX_SYS_STAT 8'h0C
`define PSP_IDX_FLAGS 8'h10
`define PSP_IDX_PROT 8'h11

// bridge_drive_config fields
`define PSP_HB_OFC 4
`define PSP_HB_GAIN 3
`define PSP_HB_CLS_HI 2
`define PSP_HB_CLS_LO 0
`define PSP_HB_MASK 8'h1F

// power_system_control fields
`define PSP_SC_STAGE_EN 7
`define PSP_SC_SRS_HI 6
`define PSP_SC_SRS_LO 5
`define PSP_SC_MASK 8'hE0

// Power output register field
`define PSP_PO_ON 1

// power_system_status fields
`define PSP_ST_LIN_LIM 6
`define PSP_ST_SOCF 5
`define PSP_ST_UV 3
`define PSP_ST_OV 2
`define PSP_ST_BRG_OC 1
`define PSP_ST_OT 0

// Interrupt flag register fields
`define PSP_IF_UV 3
`define PSP_IF_OV 2
`define PSP_IF_OT 0

// Protection config field
`define PSP_PR_HTRE 0

// Reset values
`define PSP_RST_BYTE 8'h00
`define PSP_CLS_NOLIM_MAX 3'h2

// AXI responses
`define PSP_RESP_OKAY 2'h0
`define PSP_RESP_SLVERR 2'h2

`endif

// [rtl/psp_lowside_chop.v]
// One low-side switch with current-limit chopping.
// Assumes the limit detector and re-arm pulse are synchronous to sys_clk.
`timescale 1ns/1ps

module psp_lowside_chop (
  input wire sys_clk,
  input wire rst_n,
  input wire cmd_on,
  input wire over_limit,
  input wire limit_en,
  input wire rearm,
  output wire gate_on
);

  // Chop latch: high while the switch may conduct
  reg pass_q;
  reg pass_d;

  // Trip on current above limit, re-arm on the chosen chop edge
  always @* begin
    pass_d = pass_q;
    if (rearm) begin
      pass_d = 1'b1;
    end
    if (limit_en && over_limit) begin
      pass_d = 1'b0;
    end
  end

  // Latch register; starts conducting-permitted
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pass_q <= 1'b1;
    end else begin
      pass_q <= pass_d;
    end
  end

  // Without a limit the latch is bypassed
  assign gate_on = cmd_on & (pass_q | ~limit_en);

endmodule // psp_lowside_chop

// [rtl/psp_power_stage_ctrl.v]
// Power stage protection control: bridge, supply and LIN gating plus
// the control and status registers behind an AXI4-Lite slave.
// Assumes all fault and sense inputs are synchronous to sys_clk.
//
// What this block does
// - Sense gain bit picks 500 mA or 2.5 A
// - Recirculation output high while any bridge recirculates
// - Prewarning flag; enabled limit resets and disables outputs
// - Overcurrent turns off that side, sets flag
// - Bridge overcurrent flag cleared only by write-one
// - Voltage flags disable bridges; write-one clears, re-sets
// - Three-bit field selects low-side current limit
// - Offset chop enable bit readable, writable, reset clear
// - Supply output needs stage enable and on bit
// - Supply overtemp shutdown only with temperature reset enabled
// - Supply overcurrent switches it off, sets flag
// - Supply overcurrent flag cleared only by write-one
// - Stage enable bit gates bridges, LIN, supply
// - Two-bit field selects LIN slew rate
// - LIN current-limit status bit mirrors limitation state
// - Status voltage/temperature bits mirror interrupt flags
// - Low side trips on limit, re-arms at chop rise
// - Offset chop re-arms bridges three, four on fall
`timescale 1ns/1ps
`include "psp_regs.vh"

module psp_power_stage_ctrl #(
  parameter NUM_BRIDGES = 4
) (
  input wire sys_clk,
  input wire rst_n,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Bridge commands and analog detector levels
  input wire [NUM_BRIDGES-1:0] bridge_cmd_high,
  input wire [NUM_BRIDGES-1:0] bridge_cmd_low,
  input wire [NUM_BRIDGES-1:0] low_over_limit,
  input wire [NUM_BRIDGES-1:0] recirc_sense,
  input wire high_side_overcurrent,
  input wire low_side_overcurrent,
  input wire low_voltage_monitor,
  input wire high_voltage_monitor,
  input wire overtemp_warning,
  input wire overtemp_limit,
  input wire supply_overcurrent,
  input wire lin_limit_sense,
  input wire chop_frequency_input,
  // Power stage controls
  output wire [NUM_BRIDGES-1:0] bridge_high_on,
  output wire [NUM_BRIDGES-1:0] bridge_low_on,
  output wire switched_supply_output,
  output wire lin_tx_enable,
  output wire recirculation_detect,
  output wire temp_system_reset,
  output wire sense_gain_select,
  output wire [2:0] current_limit_select,
  output wire [1:0] lin_slew_select,
  output wire offset_chop_enable
);

  // Software registers
  reg [7:0] brcfg_q; // bridge_drive_config
  reg [7:0] sysctrl_q; // power_system_control
  reg pout_on_q; // switched_supply_on
  reg prot_htre_q; // high-temperature reset enable
  // Sticky flags
  reg brg_oc_q;
  reg hs_trip_q;
  reg ls_trip_q;
  reg socf_q;
  reg uv_flag_q;
  reg ov_flag_q;
  reg ot_flag_q;
  // Registered detector mirrors
  reg recirc_q;
  reg lin_lim_q;
  reg chop_prev_q;
  // Bus state
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wlane_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // Byte address to register index, or 8'hFF when misaligned
  function [7:0] addr_to_idx;
    input [7:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        addr_to_idx = 8'hFF;
      end else begin
        addr_to_idx = {2'h0, addr[7:2]};
      end
    end
  endfunction

  // True for an index that maps a register
  function idx_mapped;
    input [7:0] idx;
    begin
      idx_mapped = (idx == `PSP_IDX_BRIDGE_CFG) || (idx == `PSP_IDX_SYS_CTRL) ||
                   (idx == `PSP_IDX_POUT) || (idx == `PSP_IDX_SYS_STAT) ||
                   (idx == `PSP_IDX_FLAGS) || (idx == `PSP_IDX_PROT);
    end
  endfunction

  // Write channel: address and data may arrive in either order
  wire aw_ok = s_axi_awvalid & ~aw_hold_q & ~bvalid_q;
  wire w_ok = s_axi_wvalid & ~w_hold_q & ~bvalid_q;
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  wire have_aw = aw_hold_q | aw_ok;
  wire have_w = w_hold_q | w_ok;
  wire wr_fire = have_aw & have_w;
  wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [7:0] wr_byte = w_hold_q ? wdata_q : s_axi_wdata[7:0];
  wire wr_lane = w_hold_q ? wlane_q : s_axi_wstrb[0];
  wire [7:0] wr_idx = addr_to_idx(wr_addr);
  // Only byte lane 0 carries register bits; upper lanes are ignored
  wire wr_en = wr_fire & wr_lane;
  wire wr_brcfg = wr_en & (wr_idx == `PSP_IDX_BRIDGE_CFG);
  wire wr_sysctrl = wr_en & (wr_idx == `PSP_IDX_SYS_CTRL);
  wire wr_pout = wr_en & (wr_idx == `PSP_IDX_POUT);
  wire wr_stat = wr_en & (wr_idx == `PSP_IDX_SYS_STAT);
  wire wr_flags = wr_en & (wr_idx == `PSP_IDX_FLAGS);
  wire wr_prot = wr_en & (wr_idx == `PSP_IDX_PROT);

  // Write-one clear strobes
  wire clr_brg_oc = wr_stat & wr_byte[`PSP_ST_BRG_OC];
  wire clr_socf = wr_stat & wr_byte[`PSP_ST_SOCF];
  wire clr_uv = wr_flags & wr_byte[`PSP_IF_UV];
  wire clr_ov = wr_flags & wr_byte[`PSP_IF_OV];
  wire clr_ot = wr_flags & wr_byte[`PSP_IF_OT];

  // Write address/data holding and response
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= `PSP_RST_BYTE;
      wdata_q <= `PSP_RST_BYTE;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PSP_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        // Both halves present: complete and answer next cycle
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (idx_mapped(wr_idx)) begin
          bresp_q <= `PSP_RESP_OKAY;
        end else begin
          bresp_q <= `PSP_RESP_SLVERR;
        end
      end else begin
        // Park whichever half came first
        if (aw_ok) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_ok) begin
          w_hold_q <= 1'b1;
          wdata_q <= s_axi_wdata[7:0];
          wlane_q <= s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Control registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brcfg_q <= `PSP_RST_BYTE;
      sysctrl_q <= `PSP_RST_BYTE;
      pout_on_q <= 1'b0;
      prot_htre_q <= 1'b0;
    end else begin
      if (wr_brcfg) begin
        brcfg_q <= wr_byte & `PSP_HB_MASK;
      end
      if (wr_sysctrl) begin
        // Reserved low five bits are dropped whatever software writes
        sysctrl_q <= wr_byte & `PSP_SC_MASK;
      end
      if (wr_pout) begin
        pout_on_q <= wr_byte[`PSP_PO_ON];
      end
      if (wr_prot) begin
        prot_htre_q <= wr_byte[`PSP_PR_HTRE];
      end
    end
  end

  wire stage_en = sysctrl_q[`PSP_SC_STAGE_EN];
  wire [2:0] cls = brcfg_q[`PSP_HB_CLS_HI:`PSP_HB_CLS_LO];
  wire offset_en = brcfg_q[`PSP_HB_OFC];

  // Outputs that only decode fields
  assign sense_gain_select = brcfg_q[`PSP_HB_GAIN];
  assign current_limit_select = cls;
  assign offset_chop_enable = offset_en;
  assign lin_slew_select = sysctrl_q[`PSP_SC_SRS_HI:`PSP_SC_SRS_LO];

  // Temperature shutdown only when the reset is enabled
  wire temp_off = prot_htre_q & overtemp_limit;
  assign temp_system_reset = temp_off;

  // Sticky flags; a set in the clearing cycle wins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_oc_q <= 1'b0;
      hs_trip_q <= 1'b0;
      ls_trip_q <= 1'b0;
      socf_q <= 1'b0;
      uv_flag_q <= 1'b0;
      ov_flag_q <= 1'b0;
      ot_flag_q <= 1'b0;
    end else begin
      brg_oc_q <= high_side_overcurrent | low_side_overcurrent |
                  (brg_oc_q & ~clr_brg_oc);
      hs_trip_q <= high_side_overcurrent | (hs_trip_q & ~clr_brg_oc);
      ls_trip_q <= low_side_overcurrent | (ls_trip_q & ~clr_brg_oc);
      socf_q <= supply_overcurrent | (socf_q & ~clr_socf);
      // Voltage flags re-set at once while the condition lasts
      uv_flag_q <= low_voltage_monitor | (uv_flag_q & ~clr_uv);
      ov_flag_q <= high_voltage_monitor | (ov_flag_q & ~clr_ov);
      ot_flag_q <= overtemp_warning | (ot_flag_q & ~clr_ot);
    end
  end

  // Detector mirrors and chop edge history
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      recirc_q <= 1'b0;
      lin_lim_q <= 1'b0;
      chop_prev_q <= 1'b0;
    end else begin
      recirc_q <= |recirc_sense;
      lin_lim_q <= lin_limit_sense;
      chop_prev_q <= chop_frequency_input;
    end
  end

  assign recirculation_detect = recirc_q;

  // Chop edges; bridges 3 and 4 use the fall with offset chopping
  wire chop_rise = chop_frequency_input & ~chop_prev_q;
  wire chop_fall = ~chop_frequency_input & chop_prev_q;
  wire rearm_late = offset_en ? chop_fall : chop_rise;
  wire limit_en = cls > `PSP_CLS_NOLIM_MAX;

  // Common bridge gating: enable, flags and live faults
  wire bridge_ok = stage_en & ~uv_flag_q & ~ov_flag_q & ~low_voltage_monitor &
                   ~high_voltage_monitor & ~temp_off;
  wire high_ok = bridge_ok & ~hs_trip_q & ~high_side_overcurrent;
  wire low_ok = bridge_ok & ~ls_trip_q & ~low_side_overcurrent;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BRIDGES; gi = gi + 1) begin : g_br
      // High side has priority when both commands are set
      assign bridge_high_on[gi] = bridge_cmd_high[gi] & high_ok;
      wire low_cmd = bridge_cmd_low[gi] & ~bridge_cmd_high[gi] & low_ok;
      wire rearm = (gi < 2) ? chop_rise : rearm_late;
      psp_lowside_chop u_chop (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cmd_on(low_cmd),
        .over_limit(low_over_limit[gi]),
        .limit_en(limit_en),
        .rearm(rearm),
        .gate_on(bridge_low_on[gi])
      );
    end
  endgenerate

  // Switched supply ignores voltage monitors by design
  assign switched_supply_output = stage_en & pout_on_q & ~socf_q &
                                  ~supply_overcurrent & ~temp_off;
  assign lin_tx_enable = stage_en & ~temp_off;

  // Status byte: voltage and temperature bits mirror the flag register
  wire [7:0] stat_byte = {1'b0, lin_lim_q, socf_q, 1'b0, uv_flag_q, ov_flag_q,
                          brg_oc_q, ot_flag_q};
  wire [7:0] flag_byte = {4'h0, uv_flag_q, ov_flag_q, 1'b0, ot_flag_q};

  // Read channel: one read at a time, data one cycle after address
  wire [7:0] rd_idx = addr_to_idx(s_axi_araddr);
  assign s_axi_arready = ~rvalid_q;
  reg [7:0] rd_byte;

  // Read multiplexer
  always @* begin
    case (rd_idx)
      `PSP_IDX_BRIDGE_CFG: rd_byte = brcfg_q;
      `PSP_IDX_SYS_CTRL: rd_byte = sysctrl_q;
      `PSP_IDX_POUT: rd_byte = {6'h00, pout_on_q, 1'b0};
      `PSP_IDX_SYS_STAT: rd_byte = stat_byte;
      `PSP_IDX_FLAGS: rd_byte = flag_byte;
      `PSP_IDX_PROT: rd_byte = {7'h00, prot_htre_q};
      default: rd_byte = `PSP_RST_BYTE;
    endcase
  end

  // Read data register
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PSP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_byte};
        if (idx_mapped(rd_idx)) begin
          rresp_q <= `PSP_RESP_OKAY;
        end else begin
          rresp_q <= `PSP_RESP_SLVERR;
        end
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // psp_power_stage_ctrl

// [sim/psp_ctrl_checker.sv]
// Port-level checks of the power stage protection block.
// Assumes one domain: sys_clk, rst_n asynchronous active low.
`timescale 1ns/1ps

module psp_ctrl_checker #(
  parameter NUM_BRIDGES = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [NUM_BRIDGES-1:0] bridge_cmd_high,
  input wire [NUM_BRIDGES-1:0] bridge_high_on,
  input wire [NUM_BRIDGES-1:0] bridge_low_on,
  input wire [NUM_BRIDGES-1:0] recirc_sense,
  input wire recirculation_detect,
  input wire high_side_overcurrent,
  input wire low_side_overcurrent,
  input wire low_voltage_monitor,
  input wire high_voltage_monitor,
  input wire supply_overcurrent,
  input wire switched_supply_output,
  input wire temp_system_reset
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Both write halves taken on one edge
  sequence seq_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // High-side fault seen, then gone
  sequence seq_hs_trip;
    high_side_overcurrent ##1 !high_side_overcurrent;
  endsequence

  AST_WR_RESP: assert property (seq_wr_taken |=> s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RECIRC_ON: assert property ((|recirc_sense) |=> recirculation_detect)
    else $error("recirculation not flagged");
  AST_RECIRC_OFF: assert property ((recirc_sense == '0) |=> !recirculation_detect)
    else $error("recirculation flag stuck");
  AST_HS_OFF: assert property (high_side_overcurrent |-> bridge_high_on == '0)
    else $error("high side on during overcurrent");
  AST_LS_OFF: assert property (low_side_overcurrent |-> bridge_low_on == '0)
    else $error("low side on during overcurrent");
  AST_VOLT: assert property (low_voltage_monitor || high_voltage_monitor |->
    (bridge_high_on | bridge_low_on) == '0)
    else $error("bridge on during voltage fault");
  AST_SUP_OC: assert property (supply_overcurrent |-> !switched_supply_output)
    else $error("supply on during overcurrent");
  AST_TRST: assert property (temp_system_reset |-> !switched_supply_output && bridge_high_on == '0)
    else $error("outputs on during temperature reset");
  AST_HS_HOLD: assert property (seq_hs_trip |-> (bridge_high_on == '0) [*2])
    else $error("high side back before flag clear");
  AST_CMD: assert property ((bridge_high_on & ~bridge_cmd_high) == '0)
    else $error("high side on without command");
endmodule // psp_ctrl_checker

bind psp_power_stage_ctrl psp_ctrl_checker #(.NUM_BRIDGES(NUM_BRIDGES)) u_chk (.*);

// [sim/psp_power_stage_ctrl_tb.sv]
// Self-checking bench: AXI4-Lite register access plus fault stimulus.
// Assumes the design sits alone on a 200 MHz clock; all drives at rising edge.
`timescale 1ns/1ps
`include "psp_regs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module psp_power_stage_ctrl_tb;
  localparam [7:0] A_HB = `PSP_IDX_BRIDGE_CFG << 2;
  localparam [7:0] A_SC = `PSP_IDX_SYS_CTRL << 2;
  localparam [7:0] A_PO = `PSP_IDX_POUT << 2;
  localparam [7:0] A_ST = `PSP_IDX_SYS_STAT << 2;
  localparam [7:0] A_IF = `PSP_IDX_FLAGS << 2;
  localparam [7:0] A_PR = `PSP_IDX_PROT << 2;
  localparam [1:0] OK = `PSP_RESP_OKAY;
  logic sys_clk = '0, rst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, chop_frequency_input = '0, lin_limit_sense = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF, bridge_cmd_high = '0, bridge_cmd_low = '0, low_over_limit = '0, recirc_sense = '0;
  logic high_side_overcurrent = '0, low_side_overcurrent = '0, low_voltage_monitor = '0, high_voltage_monitor = '0;
  logic overtemp_warning = '0, overtemp_limit = '0, supply_overcurrent = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, lin_slew_select;
  wire [31:0] s_axi_rdata;
  wire [3:0] bridge_high_on, bridge_low_on;
  wire switched_supply_output, lin_tx_enable, recirculation_detect, temp_system_reset;
  wire sense_gain_select, offset_chop_enable;
  wire [2:0] current_limit_select;
  integer bad_count = 0, cmp_count = 0, i, n;

  psp_power_stage_ctrl u_dut (.*);

  // Free-running 5 ns clock
  always #2.5 sys_clk = ~sys_clk;

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait guard; a hang ends the run as a mismatch
  task automatic guard;
    n++;
    if (n > 40) begin
      bad_count++;
      $display("mismatch timeout");
      summarize();
    end
  endtask

  task automatic tick(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input [7:0] a, input [7:0] d, input [1:0] er);
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      guard();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask

  // Read: compares data and response at the handshake edge
  task automatic rd(input [7:0] a, input [7:0] d, input [1:0] er);
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      guard();
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {24'h0, d}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  initial begin
    tick(10);
    rst_n <= 1'b1;
    rd(A_HB, 8'h00, OK);
    rd(A_SC, 8'h00, OK);
    rd(A_ST, 8'h00, OK);
    rd(8'h3C, 8'h00, `PSP_RESP_SLVERR);
    wr(8'h3C, 8'hFF, `PSP_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(A_HB, 8'h1F, OK);
    rd(A_HB, 8'h00, OK);
    s_axi_wstrb <= 4'hF;
    $display("test reset and map done");
    // Every limit code, reserved bits written high
    for (i = 0; i < 8; i++) begin
      wr(A_HB, 8'hF8 | i[7:0], OK);
      `CHK("cls", i[2:0], current_limit_select)
      `CHK("gain", 1'b1, sense_gain_select)
      `CHK("ofc", 1'b1, offset_chop_enable)
      rd(A_HB, 8'h18 | i[7:0], OK);
    end
    wr(A_HB, 8'h00, OK);
    `CHK("gain", 1'b0, sense_gain_select)
    `CHK("ofc", 1'b0, offset_chop_enable)
    // Every slew code; stage enable bit and reserved low five bits kept zero
    for (i = 0; i < 4; i++) begin
      wr(A_SC, {1'b0, i[1:0], 5'h00}, OK);
      `CHK("slew", i[1:0], lin_slew_select)
      rd(A_SC, {1'b0, i[1:0], 5'h00}, OK);
    end
    $display("test fields done");
    bridge_cmd_high <= 4'h5;
    bridge_cmd_low <= 4'hA;
    wr(A_PO, 8'h02, OK);
    `CHK("hi", 4'h0, bridge_high_on)
    `CHK("psu", 1'b0, switched_supply_output)
    wr(A_SC, 8'h80, OK);
    `CHK("hi", 4'h5, bridge_high_on)
    `CHK("lin", 1'b1, lin_tx_enable)
    `CHK("psu", 1'b1, switched_supply_output)
    // Undervoltage: flag re-sets while present, bridges stay off after
    low_voltage_monitor <= 1'b1;
    tick(2);
    `CHK("psu", 1'b1, switched_supply_output)
    rd(A_ST, 8'h08, OK);
    wr(A_IF, 8'h08, OK);
    rd(A_IF, 8'h08, OK);
    low_voltage_monitor <= 1'b0;
    tick(2);
    `CHK("lo", 4'h0, bridge_low_on)
    wr(A_IF, 8'h08, OK);
    `CHK("lo", 4'hA, bridge_low_on)
    high_voltage_monitor <= 1'b1;
    tick(2);
    rd(A_ST, 8'h04, OK);
    high_voltage_monitor <= 1'b0;
    wr(A_IF, 8'h04, OK);
    `CHK("hi", 4'h5, bridge_high_on)
    $display("test voltage done");
    // Bridge overcurrent: side kept off until a one is written
    high_side_overcurrent <= 1'b1;
    tick(2);
    high_side_overcurrent <= 1'b0;
    tick(2);
    `CHK("hi", 4'h0, bridge_high_on)
    `CHK("lo", 4'hA, bridge_low_on)
    wr(A_ST, 8'h00, OK);
    rd(A_ST, 8'h02, OK);
    wr(A_ST, 8'h02, OK);
    `CHK("hi", 4'h5, bridge_high_on)
    low_side_overcurrent <= 1'b1;
    tick(2);
    low_side_overcurrent <= 1'b0;
    supply_overcurrent <= 1'b1;
    tick(2);
    supply_overcurrent <= 1'b0;
    tick(2);
    `CHK("lo", 4'h0, bridge_low_on)
    `CHK("psu", 1'b0, switched_supply_output)
    rd(A_ST, 8'h22, OK);
    wr(A_ST, 8'h02, OK);
    `CHK("psu", 1'b0, switched_supply_output)
    `CHK("lo", 4'hA, bridge_low_on)
    wr(A_ST, 8'h20, OK);
    `CHK("psu", 1'b1, switched_supply_output)
    $display("test overcurrent done");
    // Temperature: shutdown only with the reset enable set
    overtemp_warning <= 1'b1;
    overtemp_limit <= 1'b1;
    tick(2);
    rd(A_ST, 8'h01, OK);
    `CHK("trst", 1'b0, temp_system_reset)
    `CHK("psu", 1'b1, switched_supply_output)
    wr(A_PR, 8'h01, OK);
    `CHK("trst", 1'b1, temp_system_reset)
    `CHK("lin", 1'b0, lin_tx_enable)
    `CHK("psu", 1'b0, switched_supply_output)
    overtemp_limit <= 1'b0;
    overtemp_warning <= 1'b0;
    lin_limit_sense <= 1'b1;
    recirc_sense <= 4'h4;
    wr(A_IF, 8'h01, OK);
    `CHK("recirc", 1'b1, recirculation_detect)
    rd(A_ST, 8'h40, OK);
    lin_limit_sense <= 1'b0;
    recirc_sense <= 4'h0;
    wr(A_PR, 8'h00, OK);
    `CHK("recirc", 1'b0, recirculation_detect)
    rd(A_ST, 8'h00, OK);
    $display("test temperature and status done");
    // Limit chopping with offset: pairs re-arm on opposite chop edges
    bridge_cmd_high <= 4'h0;
    bridge_cmd_low <= 4'hF;
    wr(A_HB, 8'h13, OK);
    low_over_limit <= 4'hF;
    tick(2);
    low_over_limit <= 4'h0;
    tick(2);
    `CHK("lo", 4'h0, bridge_low_on)
    chop_frequency_input <= 1'b1;
    tick(3);
    `CHK("lo", 4'h3, bridge_low_on)
    chop_frequency_input <= 1'b0;
    tick(3);
    `CHK("lo", 4'hF, bridge_low_on)
    $display("test chopping done");
    summarize();
  end
endmodule // psp_power_stage_ctrl_tb
